// [design/trim_map.svh]
// Field layout, selection codes and timing figures of the pin-programmed trim logic.
// Assumes one 30-bit fuse/trial vector holding every trim register side by side.
`ifndef TRIM_MAP_SVH
`define TRIM_MAP_SVH
`define TRIM_FUSE_W         30
`define TRIM_QC_LSB         0
`define TRIM_QC_W           2
`define TRIM_QF_LSB         2
`define TRIM_QF_W           9
`define TRIM_GC_LSB         11
`define TRIM_GC_W           2
`define TRIM_GF_LSB         13
`define TRIM_GF_W           8
`define TRIM_TC_LSB         21
`define TRIM_TC_W           5
`define TRIM_CL_LSB         26
`define TRIM_CL_W           2
`define TRIM_POL_LSB        28
`define TRIM_POL_W          1
`define TRIM_LOCK_LSB       29
`define TRIM_LOCK_W         1
`define TRIM_FIELD_MAX_W    9
`define TRIM_COARSE_LAST    9'h002
`define TRIM_TC_ALIAS_BIT   3
`define TRIM_TC_UNUSED_LO   5'h0C
`define TRIM_TC_UNUSED_HI   5'h1C
`define TRIM_MODE_CNT_ZERO  2'h0
`define TRIM_CLK_PERIOD_NS  40
`define TRIM_T_PHE_NS       20000
`define TRIM_T_PMA_NS       6000
`define TRIM_T_PLA_NS       6000
`define TRIM_QUAL_CNT_W     10
`endif

// [design/trim_pkg.sv]
// Types shared by the trim programming logic.
// Assumes trim_map.svh sits beside this file.
`include "trim_map.svh"
package trim_pkg;
  typedef enum logic [1:0] {LVL_LOW = 2'b00, LVL_MID = 2'b01, LVL_HIGH = 2'b10} pin_level_t;
  typedef enum logic [1:0] {
    ST_INITIAL = 2'b00, ST_MODE_SEL = 2'b01, ST_REG_SEL = 2'b10, ST_BIT_SEL = 2'b11
  } prog_state_t;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00, MODE_TRIAL = 2'b01, MODE_BURN = 2'b10, MODE_SEAL = 2'b11
  } prog_mode_t;
  typedef enum logic [2:0] {
    REG_QC = 3'b000, REG_QF = 3'b001, REG_GC = 3'b010, REG_GF = 3'b011,
    REG_TC = 3'b100, REG_CL = 3'b101, REG_POL = 3'b110, REG_LOCK = 3'b111
  } trim_reg_t;
  typedef enum logic [1:0] {Q_MID = 2'b00, Q_LOW = 2'b01, Q_HIGH = 2'b10} quiescent_range_t;
  typedef enum logic [1:0] {G_LOW = 2'b00, G_MID = 2'b01, G_HIGH = 2'b10} gain_range_t;
  typedef enum logic [1:0] {
    CLAMP_NONE = 2'b00, CLAMP_HALF_V = 2'b01, CLAMP_ONE_V = 2'b10
  } output_clamp_level_t;
  typedef struct packed {
    logic state_change;
    logic increment;
  } pin_event_t;
  typedef struct packed {
    quiescent_range_t                 quiescent_coarse_range;
    logic [`TRIM_QF_W-1:0]            quiescent_fine_step;
    gain_range_t                      gain_coarse_range;
    logic [`TRIM_GF_W-1:0]            gain_fine_step;
    logic [`TRIM_TC_W-1:0]            temp_coefficient_code;
    output_clamp_level_t              output_clamp_select;
    logic                             output_polarity;
    logic                             programming_seal;
  } trim_out_t;
endpackage : trim_pkg

// [design/pin_level_qualifier.sv]
// Turns the two level comparators on the output program pin into single events.
// Assumes comparator outputs are synchronous to i_sys_clk.
`timescale 1ns/1ps
`include "trim_map.svh"
module pin_level_qualifier #(
  parameter int HIGH_MIN = 500,
  parameter int MID_MIN  = 150,
  parameter int LOW_MIN  = 150
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_pin_high,
  input  wire logic                  i_pin_low,
  output trim_pkg::pin_event_t       o_event
);
  typedef struct packed {
    trim_pkg::pin_level_t          raw_prev;
    trim_pkg::pin_level_t          qual;
    logic [`TRIM_QUAL_CNT_W-1:0]   cnt;
    trim_pkg::pin_event_t          ev;
  } qual_state_t;
  qual_state_t          cur;
  qual_state_t          next_cur;
  trim_pkg::pin_level_t raw;
  logic [`TRIM_QUAL_CNT_W-1:0] need;
  always_comb begin
    if (i_pin_high) raw = trim_pkg::LVL_HIGH;
    else if (i_pin_low) raw = trim_pkg::LVL_LOW;
    else raw = trim_pkg::LVL_MID;
    unique case (raw)
      trim_pkg::LVL_HIGH: need = `TRIM_QUAL_CNT_W'(HIGH_MIN - 1);
      trim_pkg::LVL_MID:  need = `TRIM_QUAL_CNT_W'(MID_MIN - 1);
      default:            need = `TRIM_QUAL_CNT_W'(LOW_MIN - 1);
    endcase
    next_cur          = cur;
    next_cur.raw_prev = raw;
    next_cur.ev       = '0;
    if (raw != cur.raw_prev) next_cur.cnt = '0;
    else if (cur.cnt != '1) next_cur.cnt = cur.cnt + 1'b1;
    // A level counts only once it has stood its minimum time, so glitches make no event
    if (raw == cur.raw_prev && cur.cnt >= need && raw != cur.qual) begin
      next_cur.qual            = raw;
      next_cur.ev.state_change = (raw == trim_pkg::LVL_HIGH);
      next_cur.ev.increment    = (raw == trim_pkg::LVL_LOW) &&
                                 (cur.qual == trim_pkg::LVL_MID);
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cur <= '{raw_prev: trim_pkg::LVL_LOW, qual: trim_pkg::LVL_LOW, cnt: '0, ev: '0};
    end else begin
      cur <= next_cur;
    end
  end
  assign o_event = cur.ev;
endmodule : pin_level_qualifier

// [design/trim_code_decode.sv]
// Decodes the effective trim vector into the values the analog trims use.
// Assumes the vector already merges trial bits with blown fuses.
`timescale 1ns/1ps
`include "trim_map.svh"
module trim_code_decode (
  input  wire logic [`TRIM_FUSE_W-1:0] i_value,
  output trim_pkg::trim_out_t          o_trim
);
  logic [`TRIM_QC_W-1:0] qc;
  logic [`TRIM_GC_W-1:0] gc;
  logic [`TRIM_CL_W-1:0] cl;
  logic [`TRIM_TC_W-1:0] tc;
  always_comb begin
    qc = i_value[`TRIM_QC_LSB +: `TRIM_QC_W];
    gc = i_value[`TRIM_GC_LSB +: `TRIM_GC_W];
    cl = i_value[`TRIM_CL_LSB +: `TRIM_CL_W];
    tc = i_value[`TRIM_TC_LSB +: `TRIM_TC_W];
    // Code 3 only arises from blown fuses; it behaves as the wrapped code 0
    o_trim.quiescent_coarse_range = (qc == 2'h3) ? trim_pkg::Q_MID
                                                 : trim_pkg::quiescent_range_t'(qc);
    o_trim.quiescent_fine_step    = i_value[`TRIM_QF_LSB +: `TRIM_QF_W];
    o_trim.gain_coarse_range      = (gc == 2'h3) ? trim_pkg::G_LOW
                                                 : trim_pkg::gain_range_t'(gc);
    o_trim.gain_fine_step         = i_value[`TRIM_GF_LSB +: `TRIM_GF_W];
    o_trim.output_clamp_select    = (cl == 2'h3) ? trim_pkg::CLAMP_NONE
                                                 : trim_pkg::output_clamp_level_t'(cl);
    o_trim.output_polarity        = i_value[`TRIM_POL_LSB];
    o_trim.programming_seal       = i_value[`TRIM_LOCK_LSB];
    o_trim.temp_coefficient_code  = tc;
    if ((tc & `TRIM_TC_UNUSED_HI) == `TRIM_TC_UNUSED_LO ||
        (tc & `TRIM_TC_UNUSED_HI) == `TRIM_TC_UNUSED_HI) begin
      o_trim.temp_coefficient_code[`TRIM_TC_ALIAS_BIT] = 1'b0;
    end
  end
endmodule : trim_code_decode

// [design/trim_program_ctrl.sv]
// Pin-programmed trim controller: state machine, trial registers, fuse blow requests.
// Assumes comparators classify the program pin and a fuse array reports blown bits.
`timescale 1ns/1ps
`include "trim_map.svh"
module trim_program_ctrl #(
  parameter int HIGH_MIN_CYC = (`TRIM_T_PHE_NS + `TRIM_CLK_PERIOD_NS - 1) / `TRIM_CLK_PERIOD_NS,
  parameter int MID_MIN_CYC  = (`TRIM_T_PMA_NS + `TRIM_CLK_PERIOD_NS - 1) / `TRIM_CLK_PERIOD_NS,
  parameter int LOW_MIN_CYC  = (`TRIM_T_PLA_NS + `TRIM_CLK_PERIOD_NS - 1) / `TRIM_CLK_PERIOD_NS
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_pin_high,
  input  wire logic                    i_pin_low,
  input  wire logic [`TRIM_FUSE_W-1:0] i_fuse_blown,
  output trim_pkg::trim_out_t          o_trim,
  output logic                         o_blow_strobe,
  output logic [`TRIM_FUSE_W-1:0]      o_blow_mask,
  output trim_pkg::prog_state_t        o_prog_state,
  output trim_pkg::prog_mode_t         o_prog_mode,
  output trim_pkg::trim_reg_t          o_reg_sel,
  output logic                         o_locked
);

  typedef struct packed {
    trim_pkg::prog_state_t       st;
    trim_pkg::prog_mode_t        mode;
    logic [1:0]                  mode_cnt;
    trim_pkg::trim_reg_t         reg_sel;
    logic [`TRIM_FUSE_W-1:0]     trial;
    logic                        blow;
    logic [`TRIM_FUSE_W-1:0]     blow_mask;
    logic                        locked;
    trim_pkg::trim_out_t         trim;
  } ctrl_state_t;

  ctrl_state_t              cur;
  ctrl_state_t              next_cur;
  trim_pkg::pin_event_t     pin_ev;
  trim_pkg::trim_out_t      decoded;
  logic [`TRIM_FUSE_W-1:0]  effective;

  // Field position of a register inside the trial and fuse vectors
  function automatic logic [4:0] field_lsb(input trim_pkg::trim_reg_t r);
    unique case (r)
      trim_pkg::REG_QC:   field_lsb = 5'(`TRIM_QC_LSB);
      trim_pkg::REG_QF:   field_lsb = 5'(`TRIM_QF_LSB);
      trim_pkg::REG_GC:   field_lsb = 5'(`TRIM_GC_LSB);
      trim_pkg::REG_GF:   field_lsb = 5'(`TRIM_GF_LSB);
      trim_pkg::REG_TC:   field_lsb = 5'(`TRIM_TC_LSB);
      trim_pkg::REG_CL:   field_lsb = 5'(`TRIM_CL_LSB);
      trim_pkg::REG_POL:  field_lsb = 5'(`TRIM_POL_LSB);
      trim_pkg::REG_LOCK: field_lsb = 5'(`TRIM_LOCK_LSB);
    endcase
  endfunction : field_lsb

  // Width of a register in bits
  function automatic logic [3:0] field_width(input trim_pkg::trim_reg_t r);
    unique case (r)
      trim_pkg::REG_QC:   field_width = 4'(`TRIM_QC_W);
      trim_pkg::REG_QF:   field_width = 4'(`TRIM_QF_W);
      trim_pkg::REG_GC:   field_width = 4'(`TRIM_GC_W);
      trim_pkg::REG_GF:   field_width = 4'(`TRIM_GF_W);
      trim_pkg::REG_TC:   field_width = 4'(`TRIM_TC_W);
      trim_pkg::REG_CL:   field_width = 4'(`TRIM_CL_W);
      trim_pkg::REG_POL:  field_width = 4'(`TRIM_POL_W);
      trim_pkg::REG_LOCK: field_width = 4'(`TRIM_LOCK_W);
    endcase
  endfunction : field_width

  // Mask of a register placed at its position in the vector
  function automatic logic [`TRIM_FUSE_W-1:0] field_mask(input trim_pkg::trim_reg_t r);
    logic [`TRIM_FUSE_W-1:0] ones;
    ones       = (`TRIM_FUSE_W'(1) << field_width(r)) - `TRIM_FUSE_W'(1);
    field_mask = ones << field_lsb(r);
  endfunction : field_mask

  // Coarse range and clamp registers skip code 3 and wrap straight to 0
  function automatic logic is_coarse(input trim_pkg::trim_reg_t r);
    is_coarse = (r == trim_pkg::REG_QC) || (r == trim_pkg::REG_GC) ||
                (r == trim_pkg::REG_CL);
  endfunction : is_coarse

  // Trial vector with the selected register counted up by one, wrapping at its width, or after code 2 for coarse and clamp registers
  function automatic logic [`TRIM_FUSE_W-1:0] field_increment(
    input logic [`TRIM_FUSE_W-1:0] v,
    input trim_pkg::trim_reg_t     r
  );
    logic [`TRIM_FUSE_W-1:0]     mask;
    logic [`TRIM_FIELD_MAX_W-1:0] val;
    logic [`TRIM_FIELD_MAX_W-1:0] nxt;
    mask = field_mask(r);
    val  = `TRIM_FIELD_MAX_W'((v & mask) >> field_lsb(r));
    if (is_coarse(r) && val == `TRIM_COARSE_LAST) begin
      nxt = '0;
    end else begin
      nxt = val + 1'b1;
    end
    field_increment = (v & ~mask) | ((`TRIM_FUSE_W'(nxt) << field_lsb(r)) & mask);
  endfunction : field_increment

  pin_level_qualifier #(
    .HIGH_MIN (HIGH_MIN_CYC),
    .MID_MIN  (MID_MIN_CYC),
    .LOW_MIN  (LOW_MIN_CYC)
  ) u_qualifier (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_pin_high (i_pin_high),
    .i_pin_low  (i_pin_low),
    .o_event    (pin_ev)
  );

  // Blown fuses read as one whatever the trial bits hold
  assign effective = cur.trial | i_fuse_blown;

  trim_code_decode u_decode (
    .i_value (effective),
    .o_trim  (decoded)
  );

  always_comb begin
    next_cur        = cur;
    next_cur.blow   = 1'b0;
    next_cur.locked = i_fuse_blown[`TRIM_LOCK_LSB];
    // Decoded trims follow the trial bits one cycle later, so a pulse shows two cycles after its event
    next_cur.trim   = decoded;
    if (cur.locked) begin
      // Sealed part: pulses change nothing, the controller parks in its initial state
      next_cur.st = trim_pkg::ST_INITIAL;
    end else begin
      unique case (cur.st)
        trim_pkg::ST_INITIAL: begin
          if (pin_ev.state_change) begin
            next_cur.st       = trim_pkg::ST_MODE_SEL;
            next_cur.mode_cnt = `TRIM_MODE_CNT_ZERO;
          end
        end
        trim_pkg::ST_MODE_SEL: begin
          if (pin_ev.increment) begin
            next_cur.mode_cnt = cur.mode_cnt + 1'b1;
          end else if (pin_ev.state_change && cur.mode_cnt != `TRIM_MODE_CNT_ZERO) begin
            next_cur.mode = trim_pkg::prog_mode_t'(cur.mode_cnt);
            if (trim_pkg::prog_mode_t'(cur.mode_cnt) == trim_pkg::MODE_SEAL) begin
              // Sealing needs no register choice; the lock bit is the only target
              next_cur.st      = trim_pkg::ST_BIT_SEL;
              next_cur.reg_sel = trim_pkg::REG_LOCK;
              next_cur.trial   = cur.trial & ~field_mask(trim_pkg::REG_LOCK);
            end else begin
              next_cur.st      = trim_pkg::ST_REG_SEL;
              next_cur.reg_sel = trim_pkg::REG_QC;
            end
          end
        end
        trim_pkg::ST_REG_SEL: begin
          if (pin_ev.increment) begin
            if (cur.reg_sel == trim_pkg::REG_POL) begin
              next_cur.reg_sel = trim_pkg::REG_QC;
            end else begin
              next_cur.reg_sel = trim_pkg::trim_reg_t'(cur.reg_sel + 3'h1);
            end
          end else if (pin_ev.state_change) begin
            next_cur.st    = trim_pkg::ST_BIT_SEL;
            next_cur.trial = cur.trial & ~field_mask(cur.reg_sel);
          end
        end
        trim_pkg::ST_BIT_SEL: begin
          if (pin_ev.increment) begin
            next_cur.trial = field_increment(cur.trial, cur.reg_sel);
          end else if (pin_ev.state_change) begin
            next_cur.st       = trim_pkg::ST_MODE_SEL;
            next_cur.mode_cnt = `TRIM_MODE_CNT_ZERO;
            if (cur.mode != trim_pkg::MODE_TRIAL) begin
              // The mask keeps only the selected field; every set bit is requested
              next_cur.blow      = 1'b1;
              next_cur.blow_mask = cur.trial & field_mask(cur.reg_sel);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cur <= '{st:        trim_pkg::ST_INITIAL,
               mode:      trim_pkg::MODE_NONE,
               mode_cnt:  `TRIM_MODE_CNT_ZERO,
               reg_sel:   trim_pkg::REG_QC,
               trial:     '0,
               blow:      1'b0,
               blow_mask: '0,
               locked:    1'b0,
               trim:      '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign o_trim        = cur.trim;
  assign o_blow_strobe = cur.blow;
  assign o_blow_mask   = cur.blow_mask;
  assign o_prog_state  = cur.st;
  assign o_prog_mode   = cur.mode;
  assign o_reg_sel     = cur.reg_sel;
  assign o_locked      = cur.locked;

endmodule : trim_program_ctrl

// [testbench/trim_program_ctrl_asserts.sv]
// Port-level checker for the trim programming controller, bound into it.
// Assumes trim_pkg is compiled first and trim_map.svh sits on the include path.
`timescale 1ns/1ps
`include "trim_map.svh"
module trim_program_ctrl_asserts #(
  parameter int HIGH_MIN_CYC = 500,
  parameter int MID_MIN_CYC  = 150,
  parameter int LOW_MIN_CYC  = 150
) (
  input wire logic                    i_sys_clk,
  input wire logic                    i_rst_n,
  input wire logic                    i_pin_high,
  input wire logic                    i_pin_low,
  input wire logic [`TRIM_FUSE_W-1:0] i_fuse_blown,
  input trim_pkg::trim_out_t          o_trim,
  input wire logic                    o_blow_strobe,
  input wire logic [`TRIM_FUSE_W-1:0] o_blow_mask,
  input trim_pkg::prog_state_t        o_prog_state,
  input trim_pkg::prog_mode_t         o_prog_mode,
  input trim_pkg::trim_reg_t          o_reg_sel,
  input wire logic                    o_locked
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  AST_STROBE_SINGLE: assert property (o_blow_strobe |=> !o_blow_strobe)
    else $error("blow strobe held longer than one cycle");
  AST_TRIAL_NO_BLOW: assert property (o_blow_strobe
    |-> o_prog_mode != trim_pkg::MODE_TRIAL)
    else $error("fuse blow requested in trial mode");
  AST_INIT_EXIT: assert property (o_prog_state == trim_pkg::ST_INITIAL
    |=> o_prog_state inside {trim_pkg::ST_INITIAL, trim_pkg::ST_MODE_SEL})
    else $error("initial state left for a state other than mode select");
  AST_REG_WRAP: assert property (o_prog_state == trim_pkg::ST_REG_SEL
    |-> o_reg_sel != trim_pkg::REG_LOCK)
    else $error("register selection reached the lock code");
  AST_BIT_ENTRY: assert property ($changed(o_prog_state)
    && o_prog_state == trim_pkg::ST_BIT_SEL
    |-> $past(o_prog_state) == trim_pkg::ST_REG_SEL || o_prog_mode == trim_pkg::MODE_SEAL)
    else $error("bitfield state entered from the wrong state");
  AST_BIT_EXIT: assert property ($past(i_rst_n)
    && $past(o_prog_state) == trim_pkg::ST_BIT_SEL
    && o_prog_state != trim_pkg::ST_BIT_SEL |-> o_prog_state == trim_pkg::ST_MODE_SEL)
    else $error("bitfield exit did not return to mode select");
  AST_SEAL_REG: assert property (o_prog_state == trim_pkg::ST_BIT_SEL
    && o_prog_mode == trim_pkg::MODE_SEAL |-> o_reg_sel == trim_pkg::REG_LOCK)
    else $error("seal mode bitfield not on the lock register");
  AST_LOCK_PARK: assert property (o_locked [*3]
    |-> o_prog_state == trim_pkg::ST_INITIAL)
    else $error("locked part left the initial state");
  AST_MASK_HELD: assert property (!o_blow_strobe |-> $stable(o_blow_mask))
    else $error("blow mask changed without a blow strobe");
  AST_LOCK_TRACK: assert property ($past(i_rst_n)
    |-> o_locked == $past(i_fuse_blown[`TRIM_LOCK_LSB]))
    else $error("lock output does not follow the lock fuse");
  AST_LOCK_FROZEN: assert property (o_locked [*3] |=> $stable(o_trim) && !o_blow_strobe)
    else $error("locked part changed trims or blew a fuse");
  AST_TC_ALIAS: assert property (o_trim.temp_coefficient_code[3:2] != 2'h3)
    else $error("unused temperature coefficient code reached the trims");
  AST_COARSE_CODES: assert property (o_trim.quiescent_coarse_range != 2'h3
    && o_trim.gain_coarse_range != 2'h3 && o_trim.output_clamp_select != 2'h3)
    else $error("wrapped coarse or clamp code reached the trims");
  cover property (o_blow_strobe && o_prog_mode == trim_pkg::MODE_BURN);
  cover property (o_prog_state == trim_pkg::ST_BIT_SEL && o_prog_mode == trim_pkg::MODE_TRIAL);
  cover property (o_locked);
endmodule : trim_program_ctrl_asserts

bind trim_program_ctrl trim_program_ctrl_asserts #(
  .HIGH_MIN_CYC(HIGH_MIN_CYC), .MID_MIN_CYC(MID_MIN_CYC), .LOW_MIN_CYC(LOW_MIN_CYC)
) u_asserts (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_pin_high(i_pin_high), .i_pin_low(i_pin_low),
  .i_fuse_blown(i_fuse_blown), .o_trim(o_trim), .o_blow_strobe(o_blow_strobe),
  .o_blow_mask(o_blow_mask), .o_prog_state(o_prog_state), .o_prog_mode(o_prog_mode),
  .o_reg_sel(o_reg_sel), .o_locked(o_locked)
);

// [testbench/trim_programmer_model.sv]
// External pulse programmer: drives the high and low comparator levels of the pin.
// Assumes the bench calls its tasks; levels change only just after a rising edge.
`timescale 1ns/1ps
module trim_programmer_model (
  input  wire logic i_sys_clk,
  output logic      o_pin_high,
  output logic      o_pin_low
);
  // Released pin shows the sensor output, which sits in the low band
  initial begin
    o_pin_high = 1'b0;
    o_pin_low  = 1'b1;
  end
  // Holds sit above the shortened qualifier counts the bench sets
  task automatic hold(input logic hi, input logic lo, input int n);
    @(posedge i_sys_clk);
    o_pin_high <= hi;
    o_pin_low  <= lo;
    repeat (n - 1) @(posedge i_sys_clk);
  endtask : hold
  // Mid gap after each pulse so the next low counts as an increment
  task automatic high_pulse();
    hold(1'b1, 1'b0, 8);
    hold(1'b0, 1'b0, 6);
  endtask : high_pulse
  task automatic low_pulse();
    hold(1'b0, 1'b1, 6);
    hold(1'b0, 1'b0, 6);
  endtask : low_pulse
endmodule : trim_programmer_model

// [testbench/pulse_programmed_trim_register_select_test.sv]
// Self-checking bench: pulse sequences through the trim programming controller.
// Assumes design, checker and programmer model are compiled before this file.
`timescale 1ns/1ps
`include "trim_map.svh"
module pulse_programmed_trim_register_select_test;
  logic                    i_sys_clk = 1'b0;
  logic                    i_rst_n = 1'b0;
  logic                    pin_high;
  logic                    pin_low;
  logic [`TRIM_FUSE_W-1:0] fuse = 30'h0000_0004;
  logic [`TRIM_FUSE_W-1:0] o_blow_mask;
  logic [`TRIM_FUSE_W-1:0] last_mask = '0;
  logic                    o_blow_strobe;
  logic                    o_locked;
  trim_pkg::trim_out_t     o_trim;
  trim_pkg::trim_out_t     exp_trim;
  trim_pkg::prog_state_t   o_prog_state;
  trim_pkg::prog_mode_t    o_prog_mode;
  trim_pkg::trim_reg_t     o_reg_sel;
  int                      miscompares = 0;
  int                      n_tests = 0;
  int                      n_blow = 0;
  int                      fld_reg[6] = '{0, 1, 2, 3, 5, 6};
  int                      fld_cnt[6] = '{4, 510, 2, 255, 5, 1};

  always #20 i_sys_clk = ~i_sys_clk;

  trim_programmer_model u_prog (.i_sys_clk(i_sys_clk), .o_pin_high(pin_high), .o_pin_low(pin_low));

  // Short qualifier counts keep the full fine-register sweeps quick
  trim_program_ctrl #(.HIGH_MIN_CYC(4), .MID_MIN_CYC(2), .LOW_MIN_CYC(2)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_pin_high(pin_high), .i_pin_low(pin_low),
    .i_fuse_blown(fuse), .o_trim(o_trim), .o_blow_strobe(o_blow_strobe),
    .o_blow_mask(o_blow_mask), .o_prog_state(o_prog_state), .o_prog_mode(o_prog_mode),
    .o_reg_sel(o_reg_sel), .o_locked(o_locked)
  );

  // Fuse array: a strobe blows every bit of the mask
  always @(posedge i_sys_clk) begin
    if (o_blow_strobe === 1'b1) begin
      n_blow <= n_blow + 1;
      last_mask <= o_blow_mask;
      fuse <= fuse | o_blow_mask;
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  function automatic logic [4:0] tc_alias(input int k);
    logic [4:0] c;
    c = k[4:0];
    return (c[3:2] == 2'h3) ? c - 5'h08 : c;
  endfunction : tc_alias

  task automatic enter(input int m, input int r);
    repeat (m) u_prog.low_pulse();
    u_prog.high_pulse();
    chk("mode", 32'(o_prog_mode), 32'(m));
    for (int i = 1; i <= r; i++) begin
      u_prog.low_pulse();
      chk("reg_sel", 32'(o_reg_sel), 32'(i % 7));
    end
    if (m != 3) u_prog.high_pulse();
    chk("state", 32'(o_prog_state), 32'(trim_pkg::ST_BIT_SEL));
  endtask : enter

  task automatic leave();
    u_prog.high_pulse();
    chk("state", 32'(o_prog_state), 32'(trim_pkg::ST_MODE_SEL));
  endtask : leave

  initial begin
    repeat (40000) @(posedge i_sys_clk);
    miscompares++;
    close_out();
  end

  initial begin
    exp_trim = '0;
    exp_trim.quiescent_fine_step = 9'h001;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    u_prog.hold(1'b0, 1'b0, 6);
    repeat (2) u_prog.low_pulse();
    chk("state", 32'(o_prog_state), 32'(trim_pkg::ST_INITIAL));
    chk("trim", 32'(o_trim), 32'(exp_trim));
    u_prog.high_pulse();
    u_prog.high_pulse();
    chk("state", 32'(o_prog_state), 32'(trim_pkg::ST_MODE_SEL));
    enter(1, 11);
    for (int k = 1; k <= 33; k++) begin
      u_prog.low_pulse();
      exp_trim.temp_coefficient_code = tc_alias(k);
      chk("trim", 32'(o_trim), 32'(exp_trim));
    end
    leave();
    chk("trim", 32'(o_trim), 32'(exp_trim));
    enter(1, 4);
    exp_trim.temp_coefficient_code = 5'h00;
    chk("trim", 32'(o_trim), 32'(exp_trim));
    leave();
    for (int f = 0; f < 6; f++) begin
      enter(1, fld_reg[f]);
      repeat (fld_cnt[f]) u_prog.low_pulse();
      leave();
      case (fld_reg[f])
        0: exp_trim.quiescent_coarse_range = trim_pkg::Q_LOW;
        1: exp_trim.quiescent_fine_step = 9'h1FF;
        2: exp_trim.gain_coarse_range = trim_pkg::G_HIGH;
        3: exp_trim.gain_fine_step = 8'hFF;
        5: exp_trim.output_clamp_select = trim_pkg::CLAMP_ONE_V;
        default: exp_trim.output_polarity = 1'b1;
      endcase
      chk("trim", 32'(o_trim), 32'(exp_trim));
    end
    // Burn a single coefficient bit, then check it survives a fresh entry
    enter(2, 4);
    repeat (4) u_prog.low_pulse();
    leave();
    chk("blows", 32'(n_blow), 32'h1);
    chk("mask", 32'(last_mask), 32'h0080_0000);
    exp_trim.temp_coefficient_code = 5'h04;
    enter(1, 4);
    chk("trim", 32'(o_trim), 32'(exp_trim));
    leave();
    enter(3, 0);
    chk("reg_sel", 32'(o_reg_sel), 32'(trim_pkg::REG_LOCK));
    u_prog.low_pulse();
    u_prog.high_pulse();
    repeat (4) @(posedge i_sys_clk);
    chk("mask", 32'(last_mask), 32'h2000_0000);
    chk("locked", 32'(o_locked), 32'h1);
    exp_trim.programming_seal = 1'b1;
    u_prog.high_pulse();
    u_prog.low_pulse();
    u_prog.high_pulse();
    chk("state", 32'(o_prog_state), 32'(trim_pkg::ST_INITIAL));
    chk("trim", 32'(o_trim), 32'(exp_trim));
    close_out();
  end
endmodule : pulse_programmed_trim_register_select_test
